/* File: hdl/port_upper_pin_function_mux.sv */
// upper port pins 4 to 7 with function mux and ahb-lite registers
`timescale 1ns/100ps
module port_upper_pin_function_mux
	import port_upper_pkg::*;
#(
	parameter int PKG_PINS = PKG_28
) (
	// clock and reset
	input  wire  logic        hclk,
	input  wire  logic        hresetn,
	// ahb-lite slave
	input  wire  logic        hsel,
	input  wire  logic [31:0] haddr,
	input  wire  logic [1:0]  htrans,
	input  wire  logic        hwrite,
	input  wire  logic [2:0]  hsize,
	input  wire  logic [31:0] hwdata,
	input  wire  logic        hready,
	output logic [31:0]       hrdata,
	output logic              hreadyout,
	output logic              hresp,
	// pins, bit 0 is pin 4
	input  wire  logic [3:0]  pin_in,
	output logic [3:0]        pin_out,
	output logic [3:0]        pin_oe,
	output logic [3:0]        pullup_en,
	// peripheral outputs toward pins
	input  wire  logic        eccp_out,
	input  wire  logic        pwm_a_out,
	input  wire  logic        pwm_a_tristate,
	input  wire  logic        capture_unit_five_out,
	input  wire  logic        charge_pulse_en,
	input  wire  logic        charge_pulse_out,
	input  wire  logic        serial2_transmit,
	input  wire  logic        serial2_clock_out,
	input  wire  logic        serial2_data_oe,
	input  wire  logic        serial2_data_out,
	input  wire  logic        prog_mode,
	input  wire  logic        prog_data_oe,
	input  wire  logic        prog_data_out,
	// pin values and select levels toward peripherals
	output logic              eccp_capture,
	output logic              capture_unit_five_capture,
	output logic              serial2_clock,
	output logic              serial2_receive,
	output logic              serial2_sync_data,
	output logic              timer_zero_clock_in,
	output logic              timer_three_clock_in,
	output logic              timer_three_gate,
	output logic              prog_clock,
	output logic              prog_data_in,
	output logic              analog_channel_nine,
	output logic              comparator2_input_a,
	output logic              can_pin_select,
	// interrupt request toward the core
	output logic              port_change_irq,
	output logic              port_change_priority
);

	// IS28 true on the small package only, IS64 on the large one
	localparam logic IS28 = (PKG_PINS == PKG_28);
	localparam logic IS64 = (PKG_PINS == PKG_64);

	// software registers
	logic [7:0] lat_r;   // output latch
	logic [7:0] dir_r;   // direction, 1 = input
	logic [7:0] icm_r;   // main interrupt control
	logic [7:0] iep_r;   // edge and priority control
	logic [7:0] ans_r;   // analog select, high bank
	logic [7:0] fsel_r;  // function select
	// bus tracking
	bus_st_t    st_r;    // read wait state
	logic       wr_r;    // write data phase pending
	logic [7:0] adr_r;   // latched byte offset
	logic       inr_r;   // address inside our page
	// pin path
	logic [3:0] meta_r;  // first sync stage
	logic [3:0] sync_r;  // second sync stage
	logic [3:0] old_r;   // value at last port access
	// decoded
	logic       take;
	logic       wr_go;
	logic       rd_go;
	logic       pin_acc;
	logic       an9;
	logic       eccp_act;
	logic       pwma_act;
	logic       ser_act;
	logic       sync_md;
	logic [3:0] pin_rd;
	logic [3:0] mism;
	logic [7:0] rd_val;
	logic [3:0] out_nxt;
	logic [3:0] oe_nxt;

	// a transfer is taken only when the bus is ready
	assign take    = hsel & htrans[1] & hready;
	assign wr_go   = wr_r & inr_r;
	assign rd_go   = (st_r == BUS_RD) & inr_r;
	// any read or write of the pin register ends a mismatch
	assign pin_acc = (wr_go | rd_go) & (adr_r == OFF_PIN);
	assign an9     = ans_r[B_AN9];
	// peripherals that only bond out on the small package
	assign eccp_act = fsel_r[F_ECCP] & IS28;
	assign pwma_act = fsel_r[F_PWMA] & IS28;
	assign ser_act  = fsel_r[F_SER] & IS28;
	assign sync_md  = fsel_r[F_SYNC];
	// analog pin reads zero on its digital path
	assign pin_rd   = sync_r & {3'h7, ~an9};
	// only input pins compare against the old value
	assign mism = (pin_rd ^ old_r) & dir_r[7:4];

	// two-stage synchroniser on the pins
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta_r <= 4'h0;
			sync_r <= 4'h0;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
		end
	end

	// bus phases; reads take one wait so a prior write lands first
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_r      <= BUS_IDLE;
			wr_r      <= 1'b0;
			adr_r     <= 8'h00;
			inr_r     <= 1'b0;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hresp <= 1'b0; // always okay
			wr_r  <= take & hwrite;
			if (take) begin
				adr_r <= haddr[7:0];
				inr_r <= (haddr[31:8] == 24'h000000);
			end
			unique case (st_r)
				BUS_IDLE: begin
					// read seen: stall one cycle
					if (take && !hwrite) begin
						st_r      <= BUS_RD;
						hreadyout <= 1'b0;
					end
				end
				BUS_RD: begin
					st_r      <= BUS_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	// read data mux; unmapped offsets read zero
	always_comb begin
		rd_val = 8'h00;
		unique case (adr_r)
			OFF_PIN:  rd_val = {pin_rd, 4'h0};
			OFF_LAT:  rd_val = lat_r;
			OFF_DIR:  rd_val = dir_r;
			OFF_ICM:  rd_val = icm_r;
			OFF_IEP:  rd_val = iep_r;
			OFF_ANS:  rd_val = ans_r;
			OFF_FSEL: rd_val = fsel_r;
			default:  rd_val = 8'h00;
		endcase
	end

	// read data is loaded at the end of the wait cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (st_r == BUS_RD) begin
			hrdata <= inr_r ? {24'h000000, rd_val} : 32'h00000000;
		end
	end

	// latch and direction; a pin register write lands in the latch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lat_r <= RST_LAT;
			dir_r <= RST_DIR;
		end else if (wr_go) begin
			if (adr_r == OFF_PIN || adr_r == OFF_LAT) begin
				lat_r <= hwdata[7:0];
			end
			if (adr_r == OFF_DIR) begin
				dir_r <= hwdata[7:0];
			end
		end
	end

	// configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			iep_r  <= RST_IEP;
			ans_r  <= RST_ANS;
			fsel_r <= RST_FSEL;
		end else if (wr_go) begin
			if (adr_r == OFF_IEP) begin
				iep_r <= hwdata[7:0];
			end
			if (adr_r == OFF_ANS) begin
				ans_r <= hwdata[7:0];
			end
			if (adr_r == OFF_FSEL) begin
				fsel_r <= hwdata[7:0];
			end
		end
	end

	// old value snapshot on every port access
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			old_r <= 4'h0;
		end else if (pin_acc) begin
			old_r <= pin_rd;
		end
	end

	// main interrupt control; a live mismatch beats a clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			icm_r <= RST_ICM;
		end else begin
			if (wr_go && adr_r == OFF_ICM) begin
				icm_r <= hwdata[7:0];
			end
			if (|mism) begin
				icm_r[B_FLAG] <= 1'b1;
			end
		end
	end

	// interrupt request to the core
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			port_change_irq      <= 1'b0;
			port_change_priority <= 1'b0;
		end else begin
			port_change_irq      <= icm_r[B_FLAG] & icm_r[B_ENA];
			port_change_priority <= iep_r[B_PRIO];
		end
	end

	// pin drive mux: latch by default, peripherals override
	always_comb begin
		out_nxt = lat_r[7:4];
		oe_nxt  = ~dir_r[7:4];
		// pin 4
		if (charge_pulse_en) begin
			out_nxt[0] = charge_pulse_out;
			oe_nxt[0]  = 1'b1;
		end else if (an9) begin
			oe_nxt[0] = 1'b0;
		end else if (pwma_act) begin
			out_nxt[0] = pwm_a_out;
			oe_nxt[0]  = ~dir_r[4] & ~pwm_a_tristate;
		end else if (eccp_act) begin
			out_nxt[0] = eccp_out;
		end
		// pin 5
		if (fsel_r[F_CAPTURE_UNIT_FIVE]) begin
			out_nxt[1] = capture_unit_five_out;
		end
		// pin 6
		if (prog_mode) begin
			oe_nxt[2] = 1'b0;
		end else if (ser_act && !sync_md) begin
			out_nxt[2] = serial2_transmit;
		end else if (ser_act) begin
			out_nxt[2] = serial2_clock_out;
		end
		// pin 7
		if (prog_mode) begin
			out_nxt[3] = prog_data_out;
			oe_nxt[3]  = prog_data_oe;
		end else if (ser_act && sync_md) begin
			out_nxt[3] = serial2_data_out;
			oe_nxt[3]  = serial2_data_oe;
		end
	end

	// registered pin drive; pull-ups only on undriven inputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_out   <= 4'h0;
			pin_oe    <= 4'h0;
			pullup_en <= 4'h0;
		end else begin
			pin_out   <= out_nxt;
			pin_oe    <= oe_nxt;
			pullup_en <= {4{~iep_r[B_PUDN]}} & dir_r[7:4]
				& ~oe_nxt;
		end
	end

	// pin values handed to the peripherals
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			eccp_capture      <= 1'b0;
			capture_unit_five_capture      <= 1'b0;
			serial2_clock     <= 1'b0;
			serial2_receive   <= 1'b1;
			serial2_sync_data <= 1'b0;
		end else begin
			eccp_capture  <= pin_rd[0] & eccp_act & dir_r[4];
			capture_unit_five_capture  <= sync_r[1] & fsel_r[F_CAPTURE_UNIT_FIVE]
				& dir_r[5];
			serial2_clock <= sync_r[2] & ser_act & sync_md
				& dir_r[6] & ~prog_mode;
			// idle high so a blocked line never looks like a start bit
			serial2_receive <= (ser_act && !sync_md && dir_r[7])
				? sync_r[3] : 1'b1;
			serial2_sync_data <= sync_r[3] & ser_act & sync_md
				& ~serial2_data_oe;
		end
	end

	// timers, programming port, analog and pin select levels
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_zero_clock_in  <= 1'b0;
			timer_three_clock_in <= 1'b0;
			timer_three_gate     <= 1'b0;
			prog_clock           <= 1'b0;
			prog_data_in         <= 1'b0;
			analog_channel_nine  <= 1'b0;
			comparator2_input_a  <= 1'b0;
			can_pin_select       <= 1'b0;
		end else begin
			timer_zero_clock_in  <= sync_r[1]
				& fsel_r[F_T0SEL];
			timer_three_clock_in <= sync_r[1]
				& (~IS64 | ~fsel_r[F_T3SEL]);
			timer_three_gate     <= sync_r[3];
			prog_clock           <= sync_r[2] & prog_mode;
			prog_data_in         <= sync_r[3] & prog_mode;
			analog_channel_nine  <= an9;
			comparator2_input_a  <= an9 & IS28;
			can_pin_select       <= fsel_r[F_CANSEL];
		end
	end

	// checks
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence rd_take_s;
		take && !hwrite;
	endsequence
	sequence rd_done_s;
		!hreadyout ##1 hreadyout;
	endsequence

	read_wait_ok_a: assert property (rd_take_s |=> rd_done_s)
		else $error("read did not finish after one wait");
	latch_drive_a: assert property (!dir_r[5] && !fsel_r[F_CAPTURE_UNIT_FIVE]
		|=> pin_oe[1] && pin_out[1] == $past(lat_r[5]))
		else $error("latch does not drive pin 5");
	pullup_gate_a: assert property (iep_r[B_PUDN]
		|=> pullup_en == 4'h0)
		else $error("pull-up on while disabled");
	pullup_out_a: assert property ((pullup_en & pin_oe) == 4'h0)
		else $error("pull-up on a driven pin");
	pwm_float_a: assert property (pwma_act && pwm_a_tristate
		&& !charge_pulse_en |=> !pin_oe[0])
		else $error("pwm pin driven in shutdown");
	capture_unit_five_drive_a: assert property (fsel_r[F_CAPTURE_UNIT_FIVE] && !dir_r[5]
		|=> pin_oe[1] && pin_out[1] == $past(capture_unit_five_out))
		else $error("capture_unit_five output not on pin 5");
	prog_clock_a: assert property (prog_mode |=> !pin_oe[2])
		else $error("pin 6 driven in programming mode");
	gate_route_a: assert property (##3 timer_three_gate
		== $past(pin_in[3], 3))
		else $error("timer three gate not pin 7");
	pulse_drive_a: assert property (charge_pulse_en
		|=> pin_oe[0] && pin_out[0] == $past(charge_pulse_out))
		else $error("charge pulse not on pin 4");
	flag_set_a: assert property (|mism |=> icm_r[B_FLAG])
		else $error("mismatch did not set flag");
	irq_follow_a: assert property (icm_r[B_FLAG] && icm_r[B_ENA]
		|=> port_change_irq)
		else $error("enabled flag gave no request");

endmodule : port_upper_pin_function_mux

/* File: hdl/port_upper_pkg.sv */
// constants and register map of the upper port pin function mux
package port_upper_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_PIN   = 8'h00;
	localparam logic [7:0] OFF_LAT   = 8'h04;
	localparam logic [7:0] OFF_DIR   = 8'h08;
	localparam logic [7:0] OFF_ICM   = 8'h0c;
	localparam logic [7:0] OFF_IEP   = 8'h10;
	localparam logic [7:0] OFF_ANS   = 8'h14;
	localparam logic [7:0] OFF_FSEL  = 8'h18;
	// field positions
	localparam int B_FLAG   = 0;
	localparam int B_ENA    = 3;
	localparam int B_PRIO   = 0;
	localparam int B_PUDN   = 7;
	localparam int B_AN9    = 1;
	localparam int F_ECCP   = 0;
	localparam int F_PWMA   = 1;
	localparam int F_CAPTURE_UNIT_FIVE   = 2;
	localparam int F_SER    = 3;
	localparam int F_SYNC   = 4;
	localparam int F_T0SEL  = 5;
	localparam int F_T3SEL  = 6;
	localparam int F_CANSEL = 7;
	// reset values
	localparam logic [7:0] RST_LAT  = 8'h00;
	localparam logic [7:0] RST_DIR  = 8'hff;
	localparam logic [7:0] RST_ICM  = 8'h00;
	localparam logic [7:0] RST_IEP  = 8'h80;
	localparam logic [7:0] RST_ANS  = 8'h02;
	localparam logic [7:0] RST_FSEL = 8'he0;
	// package variants
	localparam int PKG_28 = 28;
	localparam int PKG_64 = 64;
	// bus states
	typedef enum logic [0:0] {BUS_IDLE = 1'b0, BUS_RD = 1'b1} bus_st_t;
endpackage : port_upper_pkg

/* File: tb/board_model.sv */
// board side of the upper port pins: external drivers and floating wire
`timescale 1ns/100ps
module board_model (
	// clock
	input  wire logic       hclk,
	// design side of the pins
	input  wire logic [3:0] pin_out,
	input  wire logic [3:0] pin_oe,
	input  wire logic [3:0] pullup_en,
	// board drivers
	input  wire logic [3:0] ext_en,
	input  wire logic [3:0] ext_val,
	// resolved wire level
	output logic      [3:0] pin_in
);
	logic [3:0] float_r = 4'h0; // drift of an undriven wire

	// a released wire drifts to the inverse of what last drove it, so a
	// stale level is never mistaken for a real one; it does not oscillate
	always_ff @(posedge hclk) begin
		for (int i = 0; i < 4; i++) begin
			if (pin_oe[i] || ext_en[i] || pullup_en[i])
				float_r[i] <= ~pin_in[i];
		end
	end

	// device first, then board, then the weak pull-up
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else if (pullup_en[i])
				pin_in[i] = 1'b1;
			else
				pin_in[i] = float_r[i];
		end
	end
endmodule : board_model

/* File: tb/tb.sv */
// self-checking bench of the upper port pin function mux
`timescale 1ns/100ps
module tb import port_upper_pkg::*;;
	logic        hclk = 1'b0; // 250 MHz
	logic        hresetn;    // active low
	logic        hsel, hwrite, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [3:0]  pin_in, pin_out, pin_oe, pullup_en, ext_en, ext_val;
	logic [12:0] pv;         // peripheral outputs toward pins
	logic        gate3, irq;
	wire  [12:0] po;         // pin values and levels toward peripherals
	int          errors = 0, samples_checked = 0;

	always #2 hclk = ~hclk;

	port_upper_pin_function_mux uut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
		.eccp_out(pv[0]), .pwm_a_out(pv[1]), .pwm_a_tristate(pv[2]),
		.capture_unit_five_out(pv[3]), .charge_pulse_en(pv[4]),
		.charge_pulse_out(pv[5]), .serial2_transmit(pv[6]),
		.serial2_clock_out(pv[7]), .serial2_data_oe(pv[8]),
		.serial2_data_out(pv[9]), .prog_mode(pv[10]),
		.prog_data_oe(pv[11]), .prog_data_out(pv[12]),
		.eccp_capture(po[0]), .capture_unit_five_capture(po[1]),
		.serial2_clock(po[2]), .serial2_receive(po[3]),
		.serial2_sync_data(po[4]), .timer_zero_clock_in(po[5]),
		.timer_three_clock_in(po[6]), .timer_three_gate(gate3),
		.prog_clock(po[7]), .prog_data_in(po[8]),
		.analog_channel_nine(po[9]), .comparator2_input_a(po[10]),
		.can_pin_select(po[11]), .port_change_irq(irq),
		.port_change_priority(po[12])
	);

	board_model brd (
		.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
		.pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val),
		.pin_in(pin_in)
	);

	// verdict and end of run
	task automatic wrap_up();
		if (errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : wrap_up

	// one comparison, four-state exact
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// wait for hready at a rising edge, bounded
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
			if (n > 40) begin
				errors++;
				wrap_up();
			end
		end while (hreadyout !== 1'b1);
	endtask : rdy

	// single word transfer: address phase, then data phase
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= {24'h0, a};
		hwrite <= w;
		rdy();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		rdy();
		rd = hrdata; // read data taken at the closing edge
	endtask : xfer

	task automatic bw(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask : bw

	task automatic ck(input int n);
		repeat (n) @(posedge hclk);
	endtask : ck

	// reset values, unmapped places read zero
	task automatic t_reset();
		chk(pullup_en, 4'h0);
		chk(pin_oe[0], 1'b0);
		xfer(0, OFF_LAT, 0); chk(rd, {24'h0, RST_LAT});
		xfer(0, OFF_DIR, 0); chk(rd, {24'h0, RST_DIR});
		xfer(0, OFF_ICM, 0); chk(rd, {24'h0, RST_ICM});
		xfer(0, OFF_IEP, 0); chk(rd, {24'h0, RST_IEP});
		xfer(0, OFF_ANS, 0); chk(rd, {24'h0, RST_ANS});
		xfer(0, OFF_FSEL, 0); chk(rd, {24'h0, RST_FSEL});
		bw(8'h1c, 8'h5a);
		xfer(0, 8'h1c, 0); chk(rd, 32'h0);
		chk(hresp, 1'b0);
		chk(po[9], 1'b1);
		chk(po[10], 1'b1);
		chk(po[11], 1'b1);
	endtask : t_reset

	// latch drives outputs, pull-ups stay off on outputs
	task automatic t_latch();
		bw(OFF_ANS, 8'h00);
		bw(OFF_FSEL, 8'h00);
		bw(OFF_IEP, 8'h00);
		bw(OFF_LAT, 8'ha0);
		bw(OFF_DIR, 8'h00);
		ck(4);
		chk(pin_oe, 4'hf);
		chk(pin_out, 4'ha);
		chk(pullup_en, 4'h0);
		chk(gate3, 1'b1);
	endtask : t_latch

	// inputs read back, pull-ups follow the disable bit
	task automatic t_input();
		ext_en  <= 4'hf;
		ext_val <= 4'h5;
		bw(OFF_DIR, 8'hf0);
		ck(4);
		chk(pullup_en, 4'hf);
		xfer(0, OFF_PIN, 0); chk(rd[7:4], 4'h5);
		bw(OFF_IEP, 8'h80);
		ck(2);
		chk(pullup_en, 4'h0);
	endtask : t_input

	// peripheral outputs beat the latch
	task automatic t_periph();
		bw(OFF_LAT, 8'h00);
		bw(OFF_FSEL, 8'h0d);
		bw(OFF_DIR, 8'h00);
		pv <= 13'h049; // eccp, capture_unit_five, transmit high
		ck(3);
		chk(pin_out[2:0], 3'h7);
		chk(pin_oe[2:0], 3'h7);
		bw(OFF_FSEL, 8'h02);
		pv <= 13'h006; // channel a high, shutdown
		ck(3);
		chk(pin_oe[0], 1'b0);
		pv <= 13'h002;
		ck(2);
		chk({pin_oe[0], pin_out[0]}, 2'h3);
		bw(OFF_DIR, 8'hff);
		pv <= 13'h010; // pulse owns pin 4, drives low
		ck(3);
		chk({pin_oe[0], pin_out[0]}, 2'h2);
		pv <= 13'h000;
	endtask : t_periph

	// change on an input pin against last read
	task automatic t_change();
		ext_val <= 4'h0;
		bw(OFF_FSEL, 8'h00);
		bw(OFF_DIR, 8'hf0);
		bw(OFF_ICM, 8'h08);
		ck(4);
		xfer(0, OFF_PIN, 0);
		// clear only once the read has ended the old mismatch
		bw(OFF_ICM, 8'h08);
		ck(4);
		xfer(0, OFF_ICM, 0); chk(rd, 32'h08);
		ext_val <= 4'h2;
		ck(6);
		chk(irq, 1'b1);
		xfer(0, OFF_ICM, 0); chk(rd, 32'h09);
		xfer(0, OFF_PIN, 0);
		ck(2);
		bw(OFF_ICM, 8'h08);
		ck(3);
		xfer(0, OFF_ICM, 0); chk(rd, 32'h08);
		chk(irq, 1'b0);
	endtask : t_change

	// serial, timer, capture and programming routes through the pins
	task automatic t_route();
		ext_val <= 4'h3;
		bw(OFF_FSEL, 8'h18);
		bw(OFF_DIR, 8'h30);
		pv <= 13'h380; // sync clock and data driven high
		ck(5);
		chk(pin_oe[3:2], 2'h3);
		chk(pin_out[3:2], 2'h3);
		chk(po[5], 1'b0);
		chk(po[6], 1'b1);
		pv <= 13'h000;
		ext_val <= 4'hc;
		bw(OFF_DIR, 8'hf0);
		ck(6);
		chk(po[2], 1'b1);
		chk(po[4], 1'b1);
		chk(po[3], 1'b1);
		ext_val <= 4'h6;
		bw(OFF_FSEL, 8'h28);
		ck(6);
		chk(po[3], 1'b0);
		chk(po[2], 1'b0);
		chk(po[5], 1'b1);
		ext_val <= 4'h3;
		bw(OFF_FSEL, 8'h05);
		ck(6);
		chk(po[1:0], 2'h3);
		chk(po[11], 1'b0);
		chk(po[9], 1'b0);
		ext_val <= 4'h7;
		pv <= 13'h1c00; // programming port drives pin 7 high
		ck(6);
		chk({pin_oe[3:2], pin_out[3]}, 3'h5);
		chk(po[8:7], 2'h3);
		pv <= 13'h000;
		bw(OFF_IEP, 8'h81);
		ck(2);
		chk(po[12], 1'b1);
	endtask : t_route

	// main sequence
	initial begin
		hresetn = 1'b0;
		hsel    = 1'b0;
		htrans  = 2'h0;
		haddr   = 32'h0;
		hwrite  = 1'b0;
		hwdata  = 32'h0;
		pv      = 13'h0;
		ext_en  = 4'h0;
		ext_val = 4'h0;
		ck(2);
		hresetn <= 1'b1;
		ck(1);
		t_reset();
		t_latch();
		t_input();
		t_periph();
		t_change();
		t_route();
		wrap_up();
	end
endmodule : tb
